// ==== logic/fenc_pkg.sv ====
package fenc_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int unsigned PAGE_W = 10;
    localparam int unsigned CNT_W = 11;
    localparam int unsigned NUM_LOCKS = 64;
    localparam int unsigned REGION_LSB = 4;
    localparam logic [9:0] SMALL1_FIRST = 10'h010;
    localparam logic [9:0] LARGE_FIRST = 10'h020;
    localparam logic [9:0] SECTOR1_FIRST = 10'h080;
    localparam logic [10:0] CNT_1 = 11'h001;
    localparam logic [10:0] CNT_4 = 11'h004;
    localparam logic [10:0] CNT_8 = 11'h008;
    localparam logic [10:0] SMALL_PAGES = 11'h010;
    localparam logic [10:0] CNT_32 = 11'h020;
    localparam logic [10:0] LARGE_PAGES = 11'h060;
    localparam logic [10:0] SECTOR_PAGES = 11'h080;
    localparam logic [10:0] ALL_PAGES = 11'h400;

    // ----------------------------------------------------------------
    // Register map and fields
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_LOCK_LO = 8'h08;
    localparam logic [7:0] OFF_LOCK_HI = 8'h0c;
    localparam logic [7:0] OFF_CFG = 8'h10;
    localparam logic [1:0] ID_AREA_SEL = 2'h1;
    localparam logic [3:0] ID_RC_WORD = 4'hc;
    localparam int unsigned CMD_OP_LSB = 0;
    localparam int unsigned CMD_ARG_LSB = 16;
    localparam int unsigned CFG_SECURITY = 0;
    localparam int unsigned CFG_BOOT = 1;
    localparam logic [63:0] LOCK_RST = 64'h0;
    localparam logic [2:0] CFG_RST = 3'h0;

    typedef enum logic [7:0] {
        CMD_WRITE_PAGE = 8'h01,
        CMD_WRITE_PAGE_LOCK = 8'h02,
        CMD_ERASE_WRITE_PAGE = 8'h03,
        CMD_ERASE_WRITE_PAGE_LOCK = 8'h04,
        CMD_MULTI_PAGE_ERASE = 8'h07,
        CMD_SECTOR_ERASE = 8'h08,
        CMD_ERASE_ALL = 8'h09,
        CMD_SET_LOCK = 8'h0a,
        CMD_CLEAR_LOCK = 8'h0b,
        CMD_SET_CFG = 8'h0c,
        CMD_CLEAR_CFG = 8'h0d,
        CMD_WRITE_SIG = 8'h10,
        CMD_ERASE_SIG = 8'h11
    } fenc_cmd_e;

    typedef enum logic [2:0] {
        KIND_ERASE = 3'b000,
        KIND_PROGRAM = 3'b001,
        KIND_ERASE_PROGRAM = 3'b010,
        KIND_ERASE_MAIN_ALL = 3'b011,
        KIND_SIG_ERASE = 3'b100,
        KIND_SIG_PROGRAM = 3'b101
    } fenc_kind_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMD_BUSY = 2'b01,
        ST_PIN_BUSY = 2'b10
    } fenc_state_e;

    typedef struct packed {
        fenc_kind_e kind;
        logic [9:0] first_page;
        logic [10:0] page_count;
    } fenc_op_s;

endpackage : fenc_pkg

// ==== logic/fenc_top.sv ====
`timescale 1ns/100ps
// Summary of operation
// RULE_01: Pages are 512 bytes; first sector is 16+16 small pages and 96 pages.
// RULE_02: Every later sector holds 128 pages of 512 bytes.
// RULE_03: Small-sector multi-page erase: code 0 four pages, code 1 eight; 2,3 illegal.
// RULE_04: Larger sectors: multi-page erase codes 1,2,3 erase aligned 8,16,32 pages.
// RULE_05: Sector erase clears the whole sector holding the given page.
// RULE_06: Erase-all clears the entire main array in one operation.
// RULE_07: Erase-write-page and erase-write-page-lock erase then program a page.
// RULE_08: Signature page has own commands; survives erase pin and erase-all.
// RULE_09: Sixty-four lock bits, each guarding one 8-Kbyte region.
// RULE_10: Program or erase into a locked region aborts and raises an interrupt.
// RULE_11: Set-lock and clear-lock commands add and remove region protection.
// RULE_12: Erase pin assertion clears every lock bit.
// RULE_13: Two identifier pages are read-only and never erased.
// RULE_14: Identifier at bytes 15..0, slow RC frequency at bytes 49..48.
// RULE_15: Three config bits by commands: security, flash boot, reserved always zero.
// RULE_16: Config bit 1 selects flash boot; erase pin clears it.
// RULE_17: Security bit set blocks debug-port access; cleared permits it again.
// RULE_18: Security bit only set by command; cleared by pin plus full erase.
// RULE_19: No pin-triggered erase while flash sits in deep power-down.
// RULE_20: Factory calibration bits fixed, untouched by erase pin.
// RULE_21: Outside party asserts pin, holds reset, power-cycles, keeps pin long enough.
// RULE_22: Software keeps pin function and power state until assertion time passes.
// RULE_23: Ready low while a command runs; commands taken only while ready.
module fenc_top #(
    // Arbitrary values, not tied to any part
    parameter logic [127:0] UID_VALUE = 128'h0f1e2d3c_4b5a6978_8796a5b4_c3d2e1f0,
    parameter logic [15:0] RC_FREQ_VALUE = 16'h8000,
    parameter logic [15:0] CAL_VALUE = 16'h0000
) (
    input wire logic MCLK_I,
    input wire logic RSTN_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic ERASE_PIN_I,
    input wire logic FLASH_DEEP_PD_I,
    output fenc_pkg::fenc_op_s FLASH_OP_O,
    output logic FLASH_REQ_O,
    input wire logic FLASH_DONE_I,
    output logic READY_O,
    output logic IRQ_O,
    output logic DBG_BLOCK_O,
    output logic BOOT_FLASH_O,
    output logic [15:0] CAL_O
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q;
    logic pin_s1_d, pin_s2_d, pin_s3_d, pin_lvl_d;
    logic pin_rise;
    fenc_pkg::fenc_state_e state_q, state_d;
    fenc_pkg::fenc_op_s op_q, op_d;
    logic [63:0] lock_q, lock_d;
    logic [2:0] cfg_q, cfg_d;
    logic lockerr_q, lockerr_d, cmderr_q, cmderr_d;
    logic pin_pend_q, pin_pend_d, lock_after_q, lock_after_d;
    logic [5:0] region_q, region_d;
    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic setup, access, cmd_wr, rd_status, idle_ready, cmd_take;
    logic [7:0] cmd_op;
    logic [15:0] cmd_arg;
    logic [9:0] arg_page;
    fenc_pkg::fenc_op_s dec_op;
    logic dec_flash, dec_bad, dec_lock_after, dec_check;
    logic [10:0] dec_last;
    logic [63:0] lock_hit;

    // ----------------------------------------------------------------
    // Erase pin synchroniser
    // ----------------------------------------------------------------
    always_comb begin
        pin_s1_d = ERASE_PIN_I;
        pin_s2_d = pin_s1_q;
        pin_s3_d = pin_s2_q;
        pin_lvl_d = (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_lvl_q;
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
            pin_lvl_q <= 1'b0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            pin_s3_q <= pin_s3_d;
            pin_lvl_q <= pin_lvl_d;
        end
    end

    assign pin_rise = pin_s2_q && pin_s3_q && !pin_lvl_q;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    assign setup = PSEL_I && !PENABLE_I;
    assign access = PSEL_I && PENABLE_I;
    assign cmd_wr = access && PWRITE_I && (PADDR_I == fenc_pkg::OFF_CMD);
    assign rd_status = access && !PWRITE_I && (PADDR_I == fenc_pkg::OFF_STATUS);
    assign cmd_op = PWDATA_I[fenc_pkg::CMD_OP_LSB +: 8];
    assign cmd_arg = PWDATA_I[fenc_pkg::CMD_ARG_LSB +: 16];
    assign arg_page = (cmd_op == fenc_pkg::CMD_MULTI_PAGE_ERASE) ? cmd_arg[11:2] : cmd_arg[9:0];

    always_comb begin
        dec_op.kind = fenc_pkg::KIND_PROGRAM;
        dec_op.first_page = arg_page;
        dec_op.page_count = fenc_pkg::CNT_1;
        dec_flash = 1'b1;
        dec_bad = 1'b0;
        dec_lock_after = 1'b0;
        dec_check = 1'b1;
        case (cmd_op)
            fenc_pkg::CMD_WRITE_PAGE: begin
                dec_op.kind = fenc_pkg::KIND_PROGRAM;
            end
            fenc_pkg::CMD_WRITE_PAGE_LOCK: begin
                dec_lock_after = 1'b1;
            end
            // RULE_07 erase then program
            fenc_pkg::CMD_ERASE_WRITE_PAGE: begin
                dec_op.kind = fenc_pkg::KIND_ERASE_PROGRAM;
            end
            fenc_pkg::CMD_ERASE_WRITE_PAGE_LOCK: begin
                dec_op.kind = fenc_pkg::KIND_ERASE_PROGRAM;
                dec_lock_after = 1'b1;
            end
            fenc_pkg::CMD_MULTI_PAGE_ERASE: begin
                dec_op.kind = fenc_pkg::KIND_ERASE;
                // RULE_03 small sector sizes
                if (arg_page < fenc_pkg::LARGE_FIRST) begin
                    dec_op.page_count = cmd_arg[0] ? fenc_pkg::CNT_8 : fenc_pkg::CNT_4;
                    dec_bad = cmd_arg[1];
                // RULE_04 larger sector sizes
                end else begin
                    dec_op.page_count = fenc_pkg::CNT_4 << cmd_arg[1:0];
                    dec_bad = (cmd_arg[1:0] == 2'h0);
                end
                dec_op.first_page = arg_page & ~(dec_op.page_count[9:0] - 10'h001);
            end
            // RULE_05 whole containing sector
            fenc_pkg::CMD_SECTOR_ERASE: begin
                dec_op.kind = fenc_pkg::KIND_ERASE;
                // RULE_01 first sector split
                if (arg_page < fenc_pkg::SMALL1_FIRST) begin
                    dec_op.first_page = 10'h000;
                    dec_op.page_count = fenc_pkg::SMALL_PAGES;
                end else if (arg_page < fenc_pkg::LARGE_FIRST) begin
                    dec_op.first_page = fenc_pkg::SMALL1_FIRST;
                    dec_op.page_count = fenc_pkg::SMALL_PAGES;
                end else if (arg_page < fenc_pkg::SECTOR1_FIRST) begin
                    dec_op.first_page = fenc_pkg::LARGE_FIRST;
                    dec_op.page_count = fenc_pkg::LARGE_PAGES;
                // RULE_02 full 128-page sectors
                end else begin
                    dec_op.first_page = {arg_page[9:7], 7'h00};
                    dec_op.page_count = fenc_pkg::SECTOR_PAGES;
                end
            end
            // RULE_06 whole main array
            fenc_pkg::CMD_ERASE_ALL: begin
                dec_op.kind = fenc_pkg::KIND_ERASE_MAIN_ALL;
                dec_op.first_page = 10'h000;
                dec_op.page_count = fenc_pkg::ALL_PAGES;
            end
            // RULE_08 signature page only
            fenc_pkg::CMD_WRITE_SIG: begin
                dec_op.kind = fenc_pkg::KIND_SIG_PROGRAM;
                dec_op.first_page = 10'h000;
                dec_check = 1'b0;
            end
            fenc_pkg::CMD_ERASE_SIG: begin
                dec_op.kind = fenc_pkg::KIND_SIG_ERASE;
                dec_op.first_page = 10'h000;
                dec_check = 1'b0;
            end
            fenc_pkg::CMD_SET_LOCK, fenc_pkg::CMD_CLEAR_LOCK: begin
                dec_flash = 1'b0;
                dec_check = 1'b0;
            end
            // RULE_15 reserved bit stays zero
            fenc_pkg::CMD_SET_CFG: begin
                dec_flash = 1'b0;
                dec_check = 1'b0;
                dec_bad = cmd_arg[1:0] > 2'h1;
            end
            // RULE_18 security never cleared by command
            fenc_pkg::CMD_CLEAR_CFG: begin
                dec_flash = 1'b0;
                dec_check = 1'b0;
                dec_bad = (cmd_arg[1:0] != 2'h1);
            end
            default: begin
                dec_flash = 1'b0;
                dec_check = 1'b0;
                dec_bad = 1'b1;
            end
        endcase
    end

    // RULE_09 region overlap per lock bit
    assign dec_last = {1'b0, dec_op.first_page} + dec_op.page_count - fenc_pkg::CNT_1;
    for (genvar i = 0; i < fenc_pkg::NUM_LOCKS; i++) begin : g_lock
        assign lock_hit[i] = lock_q[i]
            && (6'(i) >= dec_op.first_page[9:fenc_pkg::REGION_LSB])
            && (6'(i) <= dec_last[9:fenc_pkg::REGION_LSB]);
    end

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    assign idle_ready = (state_q == fenc_pkg::ST_IDLE) && !pin_pend_q;
    assign cmd_take = cmd_wr && idle_ready && !dec_bad;

    always_comb begin
        state_d = state_q;
        op_d = op_q;
        lock_d = lock_q;
        cfg_d = cfg_q;
        lockerr_d = rd_status ? 1'b0 : lockerr_q;
        cmderr_d = rd_status ? 1'b0 : cmderr_q;
        pin_pend_d = pin_pend_q;
        lock_after_d = lock_after_q;
        region_d = region_q;
        unique case (state_q)
            fenc_pkg::ST_IDLE: begin
                if (pin_pend_q) begin
                    op_d.kind = fenc_pkg::KIND_ERASE_MAIN_ALL;
                    op_d.first_page = 10'h000;
                    op_d.page_count = fenc_pkg::ALL_PAGES;
                    pin_pend_d = 1'b0;
                    state_d = fenc_pkg::ST_PIN_BUSY;
                // RULE_23 commands only while ready
                end else if (cmd_wr && !idle_ready) begin
                    cmderr_d = 1'b1;
                end else if (cmd_wr && dec_bad) begin
                    cmderr_d = 1'b1;
                // RULE_10 abort on locked target
                end else if (cmd_take && dec_check && (lock_hit != 64'h0)) begin
                    lockerr_d = 1'b1;
                end else if (cmd_take && dec_flash) begin
                    op_d = dec_op;
                    lock_after_d = dec_lock_after;
                    region_d = arg_page[9:fenc_pkg::REGION_LSB];
                    state_d = fenc_pkg::ST_CMD_BUSY;
                end else if (cmd_take) begin
                    // RULE_11 set and clear lock
                    if (cmd_op == fenc_pkg::CMD_SET_LOCK) begin
                        lock_d[arg_page[9:fenc_pkg::REGION_LSB]] = 1'b1;
                    end else if (cmd_op == fenc_pkg::CMD_CLEAR_LOCK) begin
                        lock_d[arg_page[9:fenc_pkg::REGION_LSB]] = 1'b0;
                    // RULE_15 set and clear config
                    end else if (cmd_op == fenc_pkg::CMD_SET_CFG) begin
                        cfg_d[cmd_arg[1:0]] = 1'b1;
                    end else begin
                        cfg_d[fenc_pkg::CFG_BOOT] = 1'b0;
                    end
                end
            end
            fenc_pkg::ST_CMD_BUSY: begin
                if (cmd_wr) begin
                    cmderr_d = 1'b1;
                end
                if (FLASH_DONE_I) begin
                    if (lock_after_q) begin
                        lock_d[region_q] = 1'b1;
                    end
                    state_d = fenc_pkg::ST_IDLE;
                end
            end
            fenc_pkg::ST_PIN_BUSY: begin
                if (cmd_wr) begin
                    cmderr_d = 1'b1;
                end
                // RULE_18 security cleared after full erase
                if (FLASH_DONE_I) begin
                    cfg_d[fenc_pkg::CFG_SECURITY] = 1'b0;
                    state_d = fenc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = fenc_pkg::ST_IDLE;
            end
        endcase
        // RULE_19 ignored in deep power-down
        if (pin_rise && !FLASH_DEEP_PD_I) begin
            // RULE_12 unlock everything
            lock_d = fenc_pkg::LOCK_RST;
            // RULE_16 boot selection dropped
            cfg_d[fenc_pkg::CFG_BOOT] = 1'b0;
            pin_pend_d = 1'b1;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            state_q <= fenc_pkg::ST_IDLE;
            op_q <= '0;
            lock_q <= fenc_pkg::LOCK_RST;
            cfg_q <= fenc_pkg::CFG_RST;
            lockerr_q <= 1'b0;
            cmderr_q <= 1'b0;
            pin_pend_q <= 1'b0;
            lock_after_q <= 1'b0;
            region_q <= 6'h00;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            lock_q <= lock_d;
            cfg_q <= cfg_d;
            lockerr_q <= lockerr_d;
            cmderr_q <= cmderr_d;
            pin_pend_q <= pin_pend_d;
            lock_after_q <= lock_after_d;
            region_q <= region_d;
        end
    end

    // ----------------------------------------------------------------
    // APB read path
    // ----------------------------------------------------------------
    always_comb begin
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup) begin
            prdata_d = 32'h0;
            pslverr_d = 1'b0;
            if (PADDR_I[1:0] != 2'h0) begin
                pslverr_d = 1'b1;
            end else if (PWRITE_I) begin
                pslverr_d = (PADDR_I != fenc_pkg::OFF_CMD);
            // RULE_13 identifier area read-only
            end else if (PADDR_I[7:6] == fenc_pkg::ID_AREA_SEL) begin
                // RULE_14 identifier and RC frequency bytes
                if (PADDR_I[5:4] == 2'h0) begin
                    prdata_d = UID_VALUE[{PADDR_I[3:2], 5'h00} +: 32];
                end else if (PADDR_I[5:2] == fenc_pkg::ID_RC_WORD) begin
                    prdata_d = {16'h0, RC_FREQ_VALUE};
                end
            end else begin
                case (PADDR_I)
                    fenc_pkg::OFF_STATUS: prdata_d = {29'h0, cmderr_q, lockerr_q, READY_O};
                    fenc_pkg::OFF_LOCK_LO: prdata_d = lock_q[31:0];
                    fenc_pkg::OFF_LOCK_HI: prdata_d = lock_q[63:32];
                    fenc_pkg::OFF_CFG: prdata_d = {29'h0, cfg_q};
                    default: pslverr_d = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RSTN_I) begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign PRDATA_O = prdata_q;
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = pslverr_q && access;
    assign FLASH_OP_O = op_q;
    assign FLASH_REQ_O = (state_q != fenc_pkg::ST_IDLE);
    // RULE_23 ready indication
    assign READY_O = idle_ready;
    assign IRQ_O = lockerr_q;
    // RULE_17 debug gate follows security
    assign DBG_BLOCK_O = cfg_q[fenc_pkg::CFG_SECURITY];
    assign BOOT_FLASH_O = cfg_q[fenc_pkg::CFG_BOOT];
    // RULE_20 calibration fixed
    assign CAL_O = CAL_VALUE;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!RSTN_I);

    a_ready_when_busy: assert property (FLASH_REQ_O |-> !READY_O) // RULE_23
        else $error("ready high during a flash operation");
    a_locked_abort: assert property (cmd_take && dec_check && (lock_hit != 64'h0) && !pin_pend_q
        |=> lockerr_q && !FLASH_REQ_O) // RULE_10
        else $error("locked command not aborted");
    a_pin_unlocks: assert property (pin_rise && !FLASH_DEEP_PD_I
        |=> (lock_q == 64'h0) && !BOOT_FLASH_O ##1 !READY_O) // RULE_12
        else $error("erase pin did not unlock or drop boot bit");
    a_sec_clear_cause: assert property ($fell(cfg_q[fenc_pkg::CFG_SECURITY])
        |-> $past(state_q) == fenc_pkg::ST_PIN_BUSY && $past(FLASH_DONE_I)) // RULE_18
        else $error("security cleared without pin erase");
    a_rsvd_zero: assert property (cfg_q[2] == 1'b0) // RULE_15
        else $error("reserved config bit set");
    a_deep_pd_gate: assert property (pin_rise && FLASH_DEEP_PD_I && !pin_pend_q
        |=> !pin_pend_q && ($stable(lock_q) || $past(cmd_wr) || $past(FLASH_DONE_I))) // RULE_19
        else $error("pin erase while in deep power-down");
    a_small_multi: assert property (cmd_take && !pin_pend_q
        && cmd_op == fenc_pkg::CMD_MULTI_PAGE_ERASE && arg_page < fenc_pkg::LARGE_FIRST
        && lock_hit == 64'h0
        |=> FLASH_OP_O.page_count == ($past(cmd_arg[0]) ? 11'h008 : 11'h004)) // RULE_03
        else $error("small sector multi-page count wrong");
    a_large_multi: assert property (cmd_take && !pin_pend_q && lock_hit == 64'h0
        && cmd_op == fenc_pkg::CMD_MULTI_PAGE_ERASE && arg_page >= fenc_pkg::LARGE_FIRST
        && cmd_arg[1:0] == 2'h3
        |=> FLASH_OP_O.page_count == 11'h020 && FLASH_OP_O.first_page[4:0] == 5'h00) // RULE_04
        else $error("large multi-page erase not 32 aligned pages");
    a_sector_span: assert property (cmd_take && !pin_pend_q && lock_hit == 64'h0
        && cmd_op == fenc_pkg::CMD_SECTOR_ERASE && arg_page >= fenc_pkg::SECTOR1_FIRST
        |=> FLASH_OP_O.page_count == 11'h080 && FLASH_OP_O.first_page[6:0] == 7'h00) // RULE_02
        else $error("sector erase span wrong");
    a_erase_all: assert property (cmd_take && !pin_pend_q && lock_hit == 64'h0
        && cmd_op == fenc_pkg::CMD_ERASE_ALL
        |=> FLASH_OP_O.kind == fenc_pkg::KIND_ERASE_MAIN_ALL && FLASH_OP_O.page_count == 11'h400) // RULE_06
        else $error("erase-all not whole main array");
    a_req_held: assert property (FLASH_REQ_O && !FLASH_DONE_I
        |=> FLASH_REQ_O && $stable(FLASH_OP_O)) // RULE_05
        else $error("flash request dropped before done");
    a_dbg_follow: assert property ($rose(cfg_q[fenc_pkg::CFG_SECURITY])
        |-> DBG_BLOCK_O && $past(cmd_take) && $past(cmd_op) == fenc_pkg::CMD_SET_CFG) // RULE_17
        else $error("debug block not tied to security set");

    c_multi_erase: cover property (cmd_take && cmd_op == fenc_pkg::CMD_MULTI_PAGE_ERASE
        ##1 FLASH_REQ_O ##[1:20] FLASH_DONE_I);
    c_pin_erase: cover property (state_q == fenc_pkg::ST_PIN_BUSY ##[1:50] READY_O);
    c_lock_abort: cover property (IRQ_O && !FLASH_REQ_O);

endmodule : fenc_top

// ==== tb/fenc_flash_model.sv ====
`timescale 1ns/100ps
module fenc_flash_model #(
    parameter int DELAY = 3
) (
    input wire logic clk_i,
    input wire logic req_i,
    output logic done_o = 1'h0
);
    int cnt = 0;
    always @(posedge clk_i) begin
        cnt <= (req_i && !done_o) ? cnt + 1 : 0;
        done_o <= req_i && !done_o && (cnt == DELAY);
    end
endmodule : fenc_flash_model

// ==== tb/tb.sv ====
`timescale 1ns/100ps
module tb;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, pin = 0, dpd = 0, k, e;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r;
    logic [15:0] cal;
    logic pready, pslverr, req, done, rdy, irq, dbg, boot;
    fenc_pkg::fenc_op_s op;
    int err_total = 0, samples_checked = 0, cyc = 0;
    logic [47:0] rows [12] = '{
        {8'h07, 16'h0010, 3'h0, 10'h004, 11'h004}, {8'h07, 16'h004d, 3'h0, 10'h010, 11'h008},
        {8'h07, 16'h0095, 3'h0, 10'h020, 11'h008}, {8'h07, 16'h0296, 3'h0, 10'h0a0, 11'h010},
        {8'h07, 16'h0297, 3'h0, 10'h0a0, 11'h020}, {8'h08, 16'h0005, 3'h0, 10'h000, 11'h010},
        {8'h08, 16'h001a, 3'h0, 10'h010, 11'h010}, {8'h08, 16'h0030, 3'h0, 10'h020, 11'h060},
        {8'h08, 16'h03ff, 3'h0, 10'h380, 11'h080}, {8'h09, 16'h0000, 3'h3, 10'h000, 11'h400},
        {8'h03, 16'h0012, 3'h2, 10'h012, 11'h001}, {8'h01, 16'h0100, 3'h1, 10'h100, 11'h001}};
    always #4 clk = ~clk;
    fenc_top i_fenc_top (.MCLK_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .ERASE_PIN_I(pin), .FLASH_DEEP_PD_I(dpd),
        .FLASH_OP_O(op), .FLASH_REQ_O(req), .FLASH_DONE_I(done), .READY_O(rdy),
        .IRQ_O(irq), .DBG_BLOCK_O(dbg), .BOOT_FLASH_O(boot), .CAL_O(cal));
    fenc_flash_model i_fenc_flash_model (.clk_i(clk), .req_i(req), .done_o(done));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'h1;
        k = 1'h0;
        while (k !== 1'h1) begin
            @(posedge clk);
            {k, e, r} = {pready, pslverr, prdata};
        end
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'h0, a, 32'h0);
        chk("read", x, r);
    endtask : rd
    task automatic cmd(input logic [7:0] o, input logic [15:0] g);
        apb(1'h1, 8'h00, {g, 8'h00, o});
    endtask : cmd
    task automatic wt(input logic sel, input logic v);
        repeat (50) if ((sel ? req : rdy) !== v) @(negedge clk);
        chk("wait", v, sel ? req : rdy);
    endtask : wt
    task automatic test_done();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            err_total++;
            test_done();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        @(negedge clk);
        chk("reset", 32'h10, {rdy, irq, dbg, boot, req});
        foreach (rows[i]) begin
            cmd(rows[i][47:40], rows[i][39:24]);
            @(negedge clk);
            chk("op", rows[i][23:0], {rdy, op});
            wt(1'h0, 1'h1);
        end
        cmd(8'h07, 16'h0012);
        rd(8'h04, 32'h5);
        cmd(8'h0a, 16'h0000);
        rd(8'h08, 32'h1);
        cmd(8'h08, 16'h0005);
        @(negedge clk);
        chk("irq", 32'h1, {req, irq});
        rd(8'h04, 32'h3);
        cmd(8'h0b, 16'h0000);
        rd(8'h08, 32'h0);
        cmd(8'h0c, 16'h0001);
        cmd(8'h0c, 16'h0000);
        cmd(8'h0d, 16'h0000);
        chk("cfg", 32'h3, {dbg, boot});
        rd(8'h04, 32'h5);
        cmd(8'h0a, 16'h0100);
        pin <= 1'h1;
        wt(1'h1, 1'h1);
        chk("pin op", {3'h3, 10'h000, 11'h400}, op);
        wt(1'h0, 1'h1);
        chk("cleared", 32'h0, {dbg, boot});
        rd(8'h08, 32'h0);
        pin <= 1'h0;
        rd(8'h40, 32'hc3d2e1f0);
        rd(8'h70, 32'h00008000);
        apb(1'h1, 8'h40, 32'h0);
        chk("ro err", 32'h1, e);
        dpd <= 1'h1;
        pin <= 1'h1;
        repeat (8) @(negedge clk);
        chk("pd", 32'h1, {req, rdy});
        chk("cal", 32'h0, cal);
        test_done();
    end
endmodule : tb
